// ===== rtl/wakeup_dispatch_map.svh
// Constants for the wake-up and interrupt dispatch block
`ifndef WAKEUP_DISPATCH_MAP_SVH
`define WAKEUP_DISPATCH_MAP_SVH
// ****************************************************************
// Source indices
// ****************************************************************
`define SRC_PIN_CHANGE   3'h0
`define SRC_COMPARATOR   3'h1
`define SRC_CONV_DONE    3'h2
`define SRC_SLAVE_RX     3'h3
`define SRC_LOW_VOLT_DET 3'h4
`define NUM_SOURCES      5
// ****************************************************************
// Power mode encodings on i_power_mode
// ****************************************************************
`define MODE_SLEEP       2'h0
`define MODE_IDLE        2'h1
`define MODE_GREEN       2'h2
`define MODE_NORMAL      2'h3
// ****************************************************************
// Outcome encodings on o_action
// ****************************************************************
`define ACT_NONE         3'h0
`define ACT_WAKE_NEXT    3'h1
`define ACT_WAKE_VECTOR  3'h2
`define ACT_NEXT         3'h3
`define ACT_IRQ_VECTOR   3'h4
`define ACT_WAKE_RESET   3'h5
`define ACT_RESET        3'h6
`define ACT_RESET_VAL    3'h0
`endif

// ===== rtl/wakeup_dispatch_pkg.sv
// Types for the wake-up and interrupt dispatch block
package wakeup_dispatch_pkg;
   // Per-source enable pair
   typedef struct packed {
      logic wake_en;
      logic irq_en;
   } src_enable_t;
   // Decided outcome with the source that caused it
   typedef struct packed {
      logic [2:0] action;
      logic [2:0] source;
   } outcome_t;
endpackage

// ===== rtl/wakeup_interrupt_dispatch.sv
// Wake-up and interrupt outcome decision per event source and power mode
`timescale 1ns/100ps
`include "wakeup_dispatch_map.svh"
module wakeup_interrupt_dispatch
   import wakeup_dispatch_pkg::*;
(
   // Clock and reset
   input  wire logic                           i_ref_clk,
   input  wire logic                           i_rstn,
   // Core state
   input  wire logic [1:0]                     i_power_mode,
   input  wire logic                           i_global_irq_enabled_state,
   // Event pulses, one bit per source index
   input  wire logic [`NUM_SOURCES-1:0]        i_event,
   input  wire logic                           i_low_volt_reset,
   input  wire logic                           i_watchdog_timeout,
   // Per-source enables
   input  wire logic                           i_pin_change_wake_en,
   input  wire logic                           i_pin_change_irq_en,
   input  wire logic                           i_comparator_wake_en,
   input  wire logic                           i_comparator_irq_en,
   input  wire logic                           i_conv_done_wake_en,
   input  wire logic                           i_conv_done_irq_en,
   input  wire logic                           i_slave_rx_wake_en,
   input  wire logic                           i_slave_rx_irq_en,
   input  wire logic                           i_low_volt_detect_wake_en,
   input  wire logic                           i_low_volt_detect_irq_en,
   // Decision outputs, registered
   output logic                                o_valid,
   output logic [2:0]                          o_action,
   output logic [2:0]                          o_source,
   output logic                                o_wake,
   output logic                                o_vector,
   output logic                                o_reset
);

   // ****************************************************************
   // Decision function
   // ****************************************************************
   // Sleep and idle both stop the core clock, so both count as asleep;
   // shared by the table lookup and the reset-class path
   function automatic logic is_asleep(input logic [1:0] mode);
      is_asleep = (mode == `MODE_SLEEP) || (mode == `MODE_IDLE);
   endfunction

   // Table lookup for one maskable source; wake_sleep_only marks the
   // sources whose both-enabled case wakes only from sleep, so that idle
   // then behaves like an awake mode
   function automatic logic [2:0] decide(input src_enable_t en,
                                         input logic [1:0]  mode,
                                         input logic        irq_on,
                                         input logic        wake_sleep_only);
      logic asleep;                        // Core clock stopped
      logic sleep_wake;                    // Both-enabled case wakes here
      asleep     = is_asleep(mode);
      sleep_wake = wake_sleep_only ? (mode == `MODE_SLEEP) : asleep;
      decide     = `ACT_NONE;
      // Column select by the two enables of this source
      case ({en.wake_en, en.irq_en})
         // Both off: nothing happens in any mode
         2'b00: begin
            decide = `ACT_NONE;
         end
         // Interrupt only: awake modes continue or vector
         2'b01: begin
            // Asleep: the interrupt enable alone cannot wake the core
            if (!asleep) begin
               decide = irq_on ? `ACT_IRQ_VECTOR : `ACT_NEXT;
            end
         end
         // Wake only: wake and resume, no interrupt when awake
         2'b10: begin
            // Awake: the wake enable alone raises nothing
            if (asleep) begin
               decide = `ACT_WAKE_NEXT;
            end
         end
         // Both on: wake then continue or vector
         2'b11: begin
            if (sleep_wake) begin
               decide = irq_on ? `ACT_WAKE_VECTOR : `ACT_WAKE_NEXT;
            end else begin
               // Awake, or idle for the sleep-only sources
               decide = irq_on ? `ACT_IRQ_VECTOR : `ACT_NEXT;
            end
         end
         // Unreachable for two defined bits
         default: begin
            decide = `ACT_NONE;
         end
      endcase
   endfunction

   // ****************************************************************
   // Per-source decode
   // ****************************************************************
   src_enable_t           en_w [`NUM_SOURCES];   // Enable pairs by source
   logic [2:0]            act_w [`NUM_SOURCES];  // Outcome per source
   logic                  asleep_w;              // Sleep or idle
   logic                  fatal_w;               // Reset-class event
   outcome_t              pick_w;                // Winning outcome
   outcome_t              out_d;                 // Next registered outcome
   outcome_t              out_q;                 // Registered outcome
   logic                  valid_w;               // Next outcome is not none
   logic                  wake_w;                // Next outcome wakes the core
   logic                  vector_w;              // Next outcome vectors
   logic                  reset_w;               // Next outcome resets the core

   // Gather the enable pairs into one array indexed by source
   assign en_w[`SRC_PIN_CHANGE]   = '{i_pin_change_wake_en, i_pin_change_irq_en};
   // Comparator and slave receive share the pin change table
   assign en_w[`SRC_COMPARATOR]   = '{i_comparator_wake_en, i_comparator_irq_en};
   assign en_w[`SRC_CONV_DONE]    = '{i_conv_done_wake_en, i_conv_done_irq_en};
   assign en_w[`SRC_SLAVE_RX]     = '{i_slave_rx_wake_en, i_slave_rx_irq_en};
   assign en_w[`SRC_LOW_VOLT_DET] = '{i_low_volt_detect_wake_en,
                                      i_low_volt_detect_irq_en};

   // Mode decode for the reset-class path
   assign asleep_w = is_asleep(i_power_mode);
   // Low-voltage reset and watchdog timeout share one path
   assign fatal_w  = i_low_volt_reset || i_watchdog_timeout;

   // Outcome for every source with an event this cycle
   // Sources with no event this cycle report none, so the priority
   // loop below only sees real candidates
   genvar g;
   generate
      for (g = 0; g < `NUM_SOURCES; g++) begin : g_src
         assign act_w[g] = i_event[g]
                         ? decide(en_w[g], i_power_mode, i_global_irq_enabled_state,
                                  (g == `SRC_CONV_DONE) || (g == `SRC_LOW_VOLT_DET))
                         : `ACT_NONE;
      end
   endgenerate

   // ****************************************************************
   // Priority selection
   // ****************************************************************
   // Reset events win over all; else lowest source index with an outcome
   always_comb begin
      pick_w = '{`ACT_NONE, 3'h0};
      // Walk from the highest index down so the lowest index is written last
      for (int i = `NUM_SOURCES - 1; i >= 0; i--) begin
         if (act_w[i] != `ACT_NONE) begin
            pick_w = '{act_w[i], 3'(i)};
         end
      end
      // Reset-class events ignore every enable
      if (fatal_w) begin
         pick_w = '{asleep_w ? `ACT_WAKE_RESET : `ACT_RESET, 3'(`NUM_SOURCES)};
      end
   end

   // Exactly one outcome is carried forward
   assign out_d = pick_w;

   // ****************************************************************
   // Outcome flag decode
   // ****************************************************************
   // The flags are decoded from the next outcome, not from out_q, so
   // that they change on the same edge as o_action and never lag it
   assign valid_w  = (out_d.action != `ACT_NONE);
   // Any wake-class outcome restarts the core clock
   assign wake_w   = (out_d.action == `ACT_WAKE_NEXT) ||
                     (out_d.action == `ACT_WAKE_VECTOR) ||
                     (out_d.action == `ACT_WAKE_RESET);
   // Both vectoring outcomes send the sequencer to the vector
   assign vector_w = (out_d.action == `ACT_WAKE_VECTOR) ||
                     (out_d.action == `ACT_IRQ_VECTOR);
   // Reset-class outcomes, with or without a wake first
   assign reset_w  = (out_d.action == `ACT_WAKE_RESET) ||
                     (out_d.action == `ACT_RESET);

   // ****************************************************************
   // Output registers
   // ****************************************************************
   // Outcome register
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         // Reset leaves no outcome pending
         out_q <= '{`ACT_RESET_VAL, 3'h0};
      end else begin
         // Capture this cycle's decision
         out_q <= out_d;
      end
   end

   // Flag registers, loaded from the decoded next outcome
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         // All flags low while in reset
         o_valid  <= 1'b0;
         o_wake   <= 1'b0;
         o_vector <= 1'b0;
         o_reset  <= 1'b0;
      end else begin
         o_valid  <= valid_w;
         o_wake   <= wake_w;
         o_vector <= vector_w;
         o_reset  <= reset_w;
      end
   end

   // Action and source come straight from the outcome register
   assign o_action = out_q.action;
   assign o_source = out_q.source;

endmodule

// ===== testbench/core_model.sv
// Core sequencer model holding power mode and global interrupt state
`timescale 1ns/100ps
module core_model (
   // Clock and requested state
   input  wire logic       i_ref_clk,
   input  wire logic [1:0] i_mode_req,
   input  wire logic       i_irq_on_req,
   // State seen by the dispatch block
   output logic [1:0]      o_power_mode,
   output logic            o_irq_on
);
   // State moves only on a clock edge, like the real sequencer
   always_ff @(posedge i_ref_clk) begin
      o_power_mode <= i_mode_req;
      o_irq_on     <= i_irq_on_req;
   end
endmodule

// ===== testbench/dispatch_properties.sv
// Concurrent checks on the dispatch block ports
`timescale 1ns/100ps
`include "wakeup_dispatch_map.svh"
module dispatch_properties (
   // Clock and reset
   input wire logic       i_ref_clk,
   input wire logic       i_rstn,
   // Core state and events
   input wire logic       i_global_irq_enabled_state,
   input wire logic [1:0] i_power_mode,
   input wire logic [4:0] i_event,
   input wire logic       i_low_volt_reset,
   input wire logic       i_watchdog_timeout,
   // Enables under check
   input wire logic       i_pin_change_wake_en,
   input wire logic       i_pin_change_irq_en,
   input wire logic       i_conv_done_wake_en,
   input wire logic       i_conv_done_irq_en,
   input wire logic       i_low_volt_detect_wake_en,
   input wire logic       i_low_volt_detect_irq_en,
   // Registered decision
   input wire logic       o_valid,
   input wire logic       o_reset,
   input wire logic [2:0] o_action,
   input wire logic [2:0] o_source
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   // Helper decodes
   wire rc  = i_low_volt_reset | i_watchdog_timeout;
   wire pin = (i_event == 5'h01) & !rc;
   wire slp = i_power_mode < 2'h2;
   wire irq_on = i_global_irq_enabled_state;
   property p_quiet; !(|i_event) && !rc |=> !o_valid; endproperty
   a_quiet: assert property (p_quiet) else $error("outcome without event");
   property p_pin_off;
      pin && !i_pin_change_wake_en && !i_pin_change_irq_en |=> o_action == `ACT_NONE;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("disabled pin acted");
   property p_pin_irq;
      pin && !i_pin_change_wake_en && i_pin_change_irq_en && slp |=> !o_valid;
   endproperty
   a_pin_irq: assert property (p_pin_irq) else $error("pin woke core");
   property p_pin_wake;
      pin && i_pin_change_wake_en && !i_pin_change_irq_en && slp
      |=> o_action == `ACT_WAKE_NEXT && o_source == 3'h0;
   endproperty
   a_pin_wake: assert property (p_pin_wake) else $error("pin wake wrong");
   property p_pin_both;
      pin && i_pin_change_wake_en && i_pin_change_irq_en && slp && irq_on
      |=> o_action == `ACT_WAKE_VECTOR;
   endproperty
   a_pin_both: assert property (p_pin_both) else $error("pin vector wrong");
   property p_conv_idle;
      i_event == 5'h04 && !rc && i_conv_done_wake_en && i_conv_done_irq_en && irq_on
      && i_power_mode == `MODE_IDLE |=> o_action == `ACT_IRQ_VECTOR;
   endproperty
   a_conv_idle: assert property (p_conv_idle) else $error("idle conv wrong");
   property p_lvd_irq;
      i_event == 5'h10 && !rc && !i_low_volt_detect_wake_en && i_low_volt_detect_irq_en
      && !slp && !irq_on |=> o_action == `ACT_NEXT && o_source == 3'h4;
   endproperty
   a_lvd_irq: assert property (p_lvd_irq) else $error("detect irq wrong");
   property p_rst;
      rc |=> o_reset && o_source == 3'h5
      && o_action == ($past(slp) ? `ACT_WAKE_RESET : `ACT_RESET);
   endproperty
   a_rst: assert property (p_rst) else $error("reset outcome wrong");
   c_wake_vec: cover property (o_action == `ACT_WAKE_VECTOR);
   c_irq_vec: cover property (o_action == `ACT_IRQ_VECTOR);
   c_reset: cover property (o_action == `ACT_RESET);
endmodule
bind wakeup_interrupt_dispatch dispatch_properties u_props (.*);

// ===== testbench/testbench.sv
// Self-checking bench for the wake-up dispatch block
`timescale 1ns/100ps
`include "wakeup_dispatch_map.svh"
module testbench;
   logic       i_ref_clk, i_rstn, irq_on_req, irq_on, lvr, wdog;
   logic       o_valid, o_wake, o_vector, o_reset;
   logic [1:0] mode_req, mode;
   logic [4:0] ev, wk, ie;
   logic [2:0] o_action, o_source;
   int         n_fail, comparisons;
   core_model PM (.i_ref_clk(i_ref_clk), .i_mode_req(mode_req), .i_irq_on_req(irq_on_req),
      .o_power_mode(mode), .o_irq_on(irq_on));
   wakeup_interrupt_dispatch DUT (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_power_mode(mode),
      .i_global_irq_enabled_state(irq_on), .i_event(ev), .i_low_volt_reset(lvr),
      .i_watchdog_timeout(wdog), .i_pin_change_wake_en(wk[0]), .i_pin_change_irq_en(ie[0]),
      .i_comparator_wake_en(wk[1]), .i_comparator_irq_en(ie[1]), .i_conv_done_wake_en(wk[2]),
      .i_conv_done_irq_en(ie[2]), .i_slave_rx_wake_en(wk[3]), .i_slave_rx_irq_en(ie[3]),
      .i_low_volt_detect_wake_en(wk[4]), .i_low_volt_detect_irq_en(ie[4]), .o_valid(o_valid),
      .o_action(o_action), .o_source(o_source), .o_wake(o_wake), .o_vector(o_vector),
      .o_reset(o_reset));
   initial begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   // Expected outcome; idle counts as awake for conv done and detect with both enables
   function automatic logic [2:0] exp_act(int s, logic [1:0] m, logic e, logic w, logic q);
      logic sl;
      sl = (m < 2'h2) && !(w && q && m == `MODE_IDLE && (s == 2 || s == 4));
      if (sl) return !w ? `ACT_NONE : (q && e) ? `ACT_WAKE_VECTOR : `ACT_WAKE_NEXT;
      return !q ? `ACT_NONE : e ? `ACT_IRQ_VECTOR : `ACT_NEXT;
   endfunction
   // Packs action and source into the full expected output word
   function automatic logic [9:0] pack(logic [2:0] a, logic [2:0] s);
      return {a != 3'h0, a, (a == 3'h0) ? 3'h0 : s, a inside {3'h1, 3'h2, 3'h5},
              a inside {3'h2, 3'h4}, a inside {3'h5, 3'h6}};
   endfunction
   task automatic check(logic [9:0] exp);
      comparisons++;
      if ({o_valid, o_action, o_source, o_wake, o_vector, o_reset} !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time,
                  {o_valid, o_action, o_source, o_wake, o_vector, o_reset}, exp);
      end
   endtask
   // Sets core state and enables, pulses {wdog, lvr, ev} one cycle, waits 1 ns past the edge that registers the answer
   task automatic fire(logic [1:0] m, logic e, logic [4:0] w, logic [4:0] q, logic [6:0] p);
      @(posedge i_ref_clk);
      mode_req <= m;
      irq_on_req <= e;
      wk <= w;
      ie <= q;
      @(posedge i_ref_clk);
      {wdog, lvr, ev} <= p;
      @(posedge i_ref_clk);
      {wdog, lvr, ev} <= 7'h00;
      #1;
   endtask
   task automatic end_sim;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Cuts a hang short
   initial begin
      repeat (2000) @(posedge i_ref_clk);
      n_fail++;
      end_sim();
   end
   initial begin
      {i_rstn, mode_req, irq_on_req, wk, ie, ev, lvr, wdog} = '0;
      n_fail = 0;
      comparisons = 0;
      repeat (4) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      for (int s = 0; s < 5; s++) begin
         for (int c = 0; c < 32; c++) begin
            fire(c[1:0], c[2], {5{c[3]}}, {5{c[4]}}, 7'(1 << s));
            check(pack(exp_act(s, c[1:0], c[2], c[3], c[4]), 3'(s)));
         end
      end
      $display("test source sweep done");
      for (int c = 0; c < 8; c++) begin
         fire(c[1:0], c[0], {5{c[1]}}, {5{c[2]}}, c[2] ? 7'h40 : 7'h20);
         check(pack((c[1:0] < 2) ? `ACT_WAKE_RESET : `ACT_RESET, 3'h5));
      end
      fire(`MODE_NORMAL, 1'b1, 5'h1e, 5'h1e, 7'h1f);
      check(pack(`ACT_IRQ_VECTOR, 3'h1));
      fire(`MODE_IDLE, 1'b1, 5'h1f, 5'h1f, 7'h7f);
      check(pack(`ACT_WAKE_RESET, 3'h5));
      $display("test reset and priority done");
      end_sim();
   end
endmodule
